// ==== design/emb_block.sv ====
// embedded memory block: dual-port ram, rom, fifo and 32x32 cam
//
// Contract
// [RULE_01] ram, rom, fifo or cam chosen by config
// [RULE_02] input registers sync writes; optional output pipeline
// [RULE_03] read and write together, independent port clocks
// [RULE_04] input and output sides on different clocks
// [RULE_05] six paths each registered or bypassed
// [RULE_06] fabric drives clock, enable, clear and strobes
// [RULE_07] cam: 32 words of 32 bits, all compared
// [RULE_08] don't-care stored bits never break a match
// [RULE_09] encoded output gives matching word address
// [RULE_10] unencoded: 16 lines, two cycles, 32 words
// [RULE_11] encoded users avoid writing duplicate data
// [RULE_12] unencoded flags every matching word at once; code flags words 0-15, then words 16-31 one cycle later
// [RULE_13] cam preloadable at config, writable in operation
// [RULE_14] cam word write takes two held cycles
// [RULE_15] word with don't-care bits takes three cycles
// [RULE_16] no match: lines low, found flag low
// [RULE_17] async clear zeroes register stages at once
`timescale 1ns/1ps
`include "emb_defines.svh"
module emb_block (
	input wire logic core_clk, // input side clock
	input wire logic rd_clk,   // output side clock
	input wire logic sys_rst,  // async reset, active high
	emb_if.dev       bus       // fabric-facing signals
);
	import emb_pkg::*;
	logic                  rst_any, ws_q, ws, is_cam_wr, do_cfg, do_ram_wr, do_fifo_wr, do_cam_wr, mem_we;
	logic                  full_q, rs_q, rs, empty_q, rd_go, do_fifo_rd, hi_pend_q, hi_found_q;
	logic                  f_valid, f_found, f_half, p_valid_q, p_found_q, p_half_q;
	logic                  o_valid_q, o_found_q, o_half_q;
	logic [1:0]            cam_cnt_q, cam_need;
	logic [`EMB_WORDS-1:0] vld_q, hit;
	logic [`EMB_HALF-1:0]  hi_q;
	emb_word_t             wd_q, wm_q, wd, wm, key_q, key, f_data, p_data_q, o_data_q;
	emb_word_t             mem_q [`EMB_WORDS];
	emb_word_t             dc_q  [`EMB_WORDS];
	emb_addr_t             wa_q, wa, mem_wa, ra_q, ra, hit_addr;
	emb_ptr_t              wptr_q, wptr_d, wg_q, rg_s1_q, rg_s2_q;
	emb_ptr_t              rptr_q, rptr_d, rg_q, wg_s1_q, wg_s2_q;
	assign rst_any = sys_rst | bus.aclr; // [RULE_17] [RULE_06]

	// write side input stages, loaded only while the fabric enables them
	always_ff @(posedge core_clk or posedge rst_any)
	begin
		if (rst_any)
		begin
			wd_q <= `EMB_RST_WORD; // [RULE_17]
			wm_q <= `EMB_RST_WORD;
			wa_q <= '0;
			ws_q <= 1'b0;
		end
		else if (bus.clk_en)
		begin
			wd_q <= bus.wr_data; // [RULE_02]
			wm_q <= bus.wr_mask;
			wa_q <= bus.wr_addr;
			ws_q <= bus.wr_strobe;
		end
	end

	assign wd = bus.path_reg[`EMB_P_DIN]   ? wd_q : bus.wr_data;   // [RULE_05]
	assign wm = bus.path_reg[`EMB_P_DIN]   ? wm_q : bus.wr_mask;   // [RULE_05]
	assign wa = bus.path_reg[`EMB_P_WADDR] ? wa_q : bus.wr_addr;   // [RULE_05]
	assign ws = bus.path_reg[`EMB_P_WSTB]  ? ws_q : bus.wr_strobe; // [RULE_05]
	assign do_cfg     = bus.cfg_load & bus.clk_en; // [RULE_13]
	assign do_ram_wr  = ws & bus.clk_en & (bus.mode == EMB_RAM) & ~do_cfg; // [RULE_01] [RULE_03]
	assign do_fifo_wr = ws & bus.clk_en & (bus.mode == EMB_FIFO) & ~full_q & ~do_cfg;
	assign is_cam_wr  = ws & bus.clk_en & (bus.mode == EMB_CAM) & ~do_cfg;
	assign cam_need   = (|wm) ? `EMB_CAM_WR_DC_CYC : `EMB_CAM_WR_CYC; // [RULE_14] [RULE_15]
	assign do_cam_wr  = is_cam_wr & ((cam_cnt_q + 2'h1) == cam_need); // [RULE_13]
	assign mem_we     = do_cfg | do_ram_wr | do_fifo_wr | do_cam_wr;
	assign mem_wa     = do_fifo_wr ? wptr_q[`EMB_AW-1:0] : wa;
	assign wptr_d     = wptr_q + {{(`EMB_PTR_W-1){1'b0}}, do_fifo_wr};
	// array holds no reset so preloaded contents survive a clear
	always_ff @(posedge core_clk)
	begin
		if (mem_we)
		begin
			mem_q[mem_wa] <= wd;
			dc_q[mem_wa]  <= wm; // [RULE_08]
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			vld_q <= '0;
		else if (mem_we)
			vld_q[mem_wa] <= 1'b1;
	end
	// a strobe dropped before the count completes abandons the word
	always_ff @(posedge core_clk or posedge rst_any)
	begin
		if (rst_any)
			cam_cnt_q <= 2'h0;
		else if (is_cam_wr)
			cam_cnt_q <= do_cam_wr ? 2'h0 : cam_cnt_q + 2'h1; // [RULE_14] [RULE_15]
		else if (!ws)
			cam_cnt_q <= 2'h0;
	end

	always_ff @(posedge core_clk or posedge rst_any)
	begin
		if (rst_any)
		begin
			wptr_q  <= '0;
			wg_q    <= '0;
			rg_s1_q <= '0;
			rg_s2_q <= '0;
			full_q  <= 1'b0;
		end
		else
		begin
			wptr_q  <= wptr_d;
			wg_q    <= emb_bin2gray(wptr_d);
			rg_s1_q <= rg_q;
			rg_s2_q <= rg_s1_q;
			full_q  <= emb_bin2gray(wptr_d) == {~rg_s2_q[5:4], rg_s2_q[3:0]};
		end
	end

	// read side input stages on the output clock
	always_ff @(posedge rd_clk or posedge rst_any)
	begin
		if (rst_any)
		begin
			ra_q  <= '0;
			rs_q  <= 1'b0;
			key_q <= `EMB_RST_WORD;
		end
		else if (bus.clk_en)
		begin
			ra_q  <= bus.rd_addr;
			rs_q  <= bus.rd_strobe;
			key_q <= bus.search_key;
		end
	end

	assign ra  = bus.path_reg[`EMB_P_RADDR] ? ra_q  : bus.rd_addr;    // [RULE_05]
	assign key = bus.path_reg[`EMB_P_RADDR] ? key_q : bus.search_key;
	assign rs  = bus.path_reg[`EMB_P_RSTB]  ? rs_q  : bus.rd_strobe;  // [RULE_05]
	// the second half of an unencoded answer blocks new reads for a cycle
	assign rd_go      = rs & bus.clk_en & ~hi_pend_q;
	assign do_fifo_rd = rd_go & (bus.mode == EMB_FIFO) & ~empty_q;
	assign rptr_d     = rptr_q + {{(`EMB_PTR_W-1){1'b0}}, do_fifo_rd};
	always_ff @(posedge rd_clk or posedge rst_any)
	begin
		if (rst_any)
		begin
			rptr_q  <= '0;
			rg_q    <= '0;
			wg_s1_q <= '0;
			wg_s2_q <= '0;
			empty_q <= 1'b1;
		end
		else
		begin
			rptr_q  <= rptr_d;
			rg_q    <= emb_bin2gray(rptr_d);
			wg_s1_q <= wg_q;
			wg_s2_q <= wg_s1_q;
			empty_q <= emb_bin2gray(rptr_d) == wg_s2_q;
		end
	end
	// lowest matching index wins the encoded address
	always_comb
	begin
		hit      = '0;
		hit_addr = '0;
		for (int i = `EMB_WORDS - 1; i >= 0; i--)
		begin
			hit[i] = vld_q[i] && (((mem_q[i] ^ key) & ~dc_q[i]) == '0); // [RULE_07] [RULE_08] [RULE_12]
			if (hit[i])
				hit_addr = i[`EMB_AW-1:0]; // [RULE_11]
		end
	end
	always_comb
	begin
		f_data  = `EMB_RST_WORD;
		f_valid = 1'b0;
		f_found = 1'b0;
		f_half  = 1'b0;
		if (hi_pend_q)
		begin
			f_valid = 1'b1;
			f_found = hi_found_q;
			f_half  = 1'b1;
			f_data  = {`EMB_RST_HALF, hi_q}; // [RULE_10]
		end
		else if (rd_go)
		begin
			case (bus.mode)
				EMB_RAM, EMB_ROM:
				begin
					f_valid = 1'b1;
					f_data  = mem_q[ra]; // [RULE_03]
				end
				EMB_FIFO:
				begin
					f_valid = ~empty_q;
					f_data  = empty_q ? `EMB_RST_WORD : mem_q[rptr_q[`EMB_AW-1:0]];
				end
				default:
				begin
					f_valid = 1'b1;
					f_found = |hit; // [RULE_16]
					if (bus.cam_unenc)
						f_data = {`EMB_RST_HALF, hit[`EMB_HALF-1:0]}; // [RULE_10] [RULE_12]
					else
						f_data = {{(`EMB_WIDTH-`EMB_AW){1'b0}}, hit_addr}; // [RULE_09]
				end
			endcase
		end
	end
	always_ff @(posedge rd_clk or posedge rst_any)
	begin
		if (rst_any)
		begin
			hi_pend_q  <= 1'b0;
			hi_q       <= `EMB_RST_HALF;
			hi_found_q <= 1'b0;
		end
		else
		begin
			hi_pend_q  <= rd_go & (bus.mode == EMB_CAM) & bus.cam_unenc; // [RULE_10]
			hi_q       <= hit[`EMB_WORDS-1:`EMB_HALF];
			hi_found_q <= |hit;
		end
	end
	// optional pipeline stage; bypass loads the output flops directly
	always_ff @(posedge rd_clk or posedge rst_any)
	begin
		if (rst_any)
		begin
			p_data_q  <= `EMB_RST_WORD;
			p_valid_q <= 1'b0;
			p_found_q <= 1'b0;
			p_half_q  <= 1'b0;
			o_data_q  <= `EMB_RST_WORD;
			o_valid_q <= 1'b0;
			o_found_q <= 1'b0;
			o_half_q  <= 1'b0;
		end
		else
		begin
			p_data_q  <= f_data;
			p_valid_q <= f_valid;
			p_found_q <= f_found;
			p_half_q  <= f_half;
			o_data_q  <= bus.path_reg[`EMB_P_DOUT] ? p_data_q  : f_data;  // [RULE_02] [RULE_05] [RULE_04]
			o_valid_q <= bus.path_reg[`EMB_P_DOUT] ? p_valid_q : f_valid;
			o_found_q <= bus.path_reg[`EMB_P_DOUT] ? p_found_q : f_found;
			o_half_q  <= bus.path_reg[`EMB_P_DOUT] ? p_half_q  : f_half;
		end
	end
	assign bus.rd_data     = o_data_q;
	assign bus.rd_valid    = o_valid_q;
	assign bus.match_found = o_found_q;
	assign bus.unenc_half  = o_half_q;
	assign bus.fifo_full   = full_q;
	assign bus.fifo_empty  = empty_q;
endmodule : emb_block

// ==== design/emb_defines.svh ====
// shared constants of the embedded memory block
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH
`define EMB_WORDS        32
`define EMB_WIDTH        32
`define EMB_AW           5
`define EMB_HALF         16
`define EMB_PTR_W        6
`define EMB_PATHS        6
`define EMB_P_DIN        0
`define EMB_P_DOUT       1
`define EMB_P_RADDR      2
`define EMB_P_WADDR      3
`define EMB_P_WSTB       4
`define EMB_P_RSTB       5
`define EMB_CAM_WR_CYC   2'h2
`define EMB_CAM_WR_DC_CYC 2'h3
`define EMB_RST_WORD     32'h0000_0000
`define EMB_RST_HALF     16'h0000
`endif

// ==== design/emb_if.sv ====
// connection between the memory block and the user logic driving it
`timescale 1ns/1ps
interface emb_if;
	import emb_pkg::*;
	emb_mode_t mode;
	emb_path_t path_reg;
	logic      cam_unenc;
	logic      clk_en;
	logic      aclr;
	logic      cfg_load;
	logic      wr_strobe;
	emb_addr_t wr_addr;
	emb_word_t wr_data;
	emb_word_t wr_mask;
	logic      rd_strobe;
	emb_addr_t rd_addr;
	emb_word_t search_key;
	emb_word_t rd_data;
	logic      rd_valid;
	logic      match_found;
	logic      unenc_half;
	logic      fifo_full;
	logic      fifo_empty;

	modport dev (
		input  mode, path_reg, cam_unenc, clk_en, aclr, cfg_load, wr_strobe, wr_addr, wr_data, wr_mask,
		input  rd_strobe, rd_addr, search_key,
		output rd_data, rd_valid, match_found, unenc_half, fifo_full, fifo_empty
	);
	modport usr (
		output mode, path_reg, cam_unenc, clk_en, aclr, cfg_load, wr_strobe, wr_addr, wr_data, wr_mask,
		output rd_strobe, rd_addr, search_key,
		input  rd_data, rd_valid, match_found, unenc_half, fifo_full, fifo_empty
	);
endinterface : emb_if

// ==== design/emb_pkg.sv ====
// types and helpers shared by both ends of the memory block
`include "emb_defines.svh"
package emb_pkg;
	typedef enum logic [1:0] {EMB_RAM, EMB_ROM, EMB_FIFO, EMB_CAM} emb_mode_t;
	typedef enum logic {EMB_U_IDLE, EMB_U_WRITE} emb_ust_t;
	typedef logic [`EMB_WIDTH-1:0] emb_word_t;
	typedef logic [`EMB_AW-1:0]    emb_addr_t;
	typedef logic [`EMB_PATHS-1:0] emb_path_t;
	typedef logic [`EMB_PTR_W-1:0] emb_ptr_t;

	function automatic emb_ptr_t emb_bin2gray(input emb_ptr_t b);
		return b ^ (b >> 1);
	endfunction : emb_bin2gray
endpackage : emb_pkg

// ==== design/emb_user.sv ====
// fabric logic end that drives the memory block
`timescale 1ns/1ps
`include "emb_defines.svh"
module emb_user (
	input wire logic              core_clk,   // write side clock
	input wire logic              rd_clk,     // read side clock
	input wire logic              sys_rst,    // async reset, active high
	emb_if.usr                    bus,        // toward the memory block
	input wire emb_pkg::emb_mode_t u_mode,    // operating mode
	input wire emb_pkg::emb_path_t u_path_reg, // register/bypass per path
	input wire logic              u_unenc,    // cam unencoded output
	input wire logic              u_clk_en,   // block clock enable
	input wire logic              u_clear,    // block async clear
	input wire logic              u_cfg_go,   // preload pulse
	input wire logic              u_wr_go,    // write request pulse
	input wire emb_pkg::emb_addr_t u_wr_addr, // write address
	input wire emb_pkg::emb_word_t u_wr_data, // write data
	input wire emb_pkg::emb_word_t u_wr_mask, // don't-care bits
	output logic                  u_wr_busy,  // strobe being held
	input wire logic              u_rd_go,    // read/search pulse
	input wire emb_pkg::emb_addr_t u_rd_addr, // read address
	input wire emb_pkg::emb_word_t u_key,     // search word
	output emb_pkg::emb_word_t    u_rd_data,  // returned data
	output logic                  u_rd_valid, // returned data valid
	output logic                  u_found,    // match found
	output logic                  u_half      // upper match half
);
	import emb_pkg::*;

	emb_ust_t  st_q;
	logic [1:0] left_q;
	emb_mode_t mode_q;
	emb_path_t path_q;
	logic      unenc_q;
	logic      ce_q;
	logic      clr_q;
	logic      cfg_q;
	logic      ws_q;
	emb_addr_t wa_q;
	emb_word_t wd_q;
	emb_word_t wm_q;
	logic      rs_q;
	emb_addr_t ra_q;
	emb_word_t key_q;
	logic      start;
	logic      cam;

	assign start = u_wr_go & (st_q == EMB_U_IDLE);
	assign cam   = mode_q == EMB_CAM;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mode_q  <= EMB_RAM;
			path_q  <= '0;
			unenc_q <= 1'b0;
			ce_q    <= 1'b0;
			clr_q   <= 1'b0;
			cfg_q   <= 1'b0;
		end
		else
		begin
			mode_q  <= u_mode;
			path_q  <= u_path_reg;
			unenc_q <= u_unenc;
			ce_q    <= u_clk_en;  // [RULE_06]
			clr_q   <= u_clear;
			cfg_q   <= u_cfg_go;
		end
	end

	// cam words keep the strobe for two cycles, three with don't-cares
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q   <= EMB_U_IDLE;
			left_q <= 2'h0;
			ws_q   <= 1'b0;
			wa_q   <= '0;
			wd_q   <= `EMB_RST_WORD;
			wm_q   <= `EMB_RST_WORD;
		end
		else if (st_q == EMB_U_IDLE)
		begin
			ws_q <= start; // [RULE_06]
			// preload needs its own address and word on the bus too
			if (start || u_cfg_go)
			begin
				wa_q <= u_wr_addr; // [RULE_13]
				wd_q <= u_wr_data;
				wm_q <= u_wr_mask;
			end
			if (start)
			begin
				left_q <= ((|u_wr_mask) ? `EMB_CAM_WR_DC_CYC : `EMB_CAM_WR_CYC) - 2'h1; // [RULE_14] [RULE_15]
				st_q   <= cam ? EMB_U_WRITE : EMB_U_IDLE;
			end
		end
		else if (left_q == 2'h0)
		begin
			ws_q <= 1'b0;
			st_q <= EMB_U_IDLE;
		end
		else
			left_q <= left_q - 2'h1; // [RULE_14]
	end

	always_ff @(posedge rd_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rs_q       <= 1'b0;
			ra_q       <= '0;
			key_q      <= `EMB_RST_WORD;
			u_rd_data  <= `EMB_RST_WORD;
			u_rd_valid <= 1'b0;
			u_found    <= 1'b0;
			u_half     <= 1'b0;
		end
		else
		begin
			rs_q <= u_rd_go; // [RULE_06]
			if (u_rd_go)
			begin
				ra_q  <= u_rd_addr;
				key_q <= u_key;
			end
			u_rd_data  <= bus.rd_data;
			u_rd_valid <= bus.rd_valid;
			u_found    <= bus.match_found; // [RULE_11]
			u_half     <= bus.unenc_half;
		end
	end

	assign u_wr_busy     = ws_q;
	assign bus.mode      = mode_q;
	assign bus.path_reg  = path_q;
	assign bus.cam_unenc = unenc_q;
	assign bus.clk_en    = ce_q;
	assign bus.aclr      = clr_q;
	assign bus.cfg_load  = cfg_q;
	assign bus.wr_strobe = ws_q;
	assign bus.wr_addr   = wa_q;
	assign bus.wr_data   = wd_q;
	assign bus.wr_mask   = wm_q;
	assign bus.rd_strobe = rs_q;
	assign bus.rd_addr   = ra_q;
	assign bus.search_key = key_q;
endmodule : emb_user

// ==== test/emb_chk_sva.sv ====
// assertions on the interface between user end and memory block
`timescale 1ns/1ps
module emb_chk (
	input wire logic               core_clk,    // write side clock
	input wire logic               rd_clk,      // read side clock
	input wire logic               sys_rst,     // async reset
	input wire emb_pkg::emb_mode_t mode,        // operating mode
	input wire emb_pkg::emb_path_t path_reg,    // stage selects
	input wire logic               cam_unenc,   // unencoded answer
	input wire logic               clk_en,      // clock enable
	input wire logic               aclr,        // block clear
	input wire logic               wr_strobe,   // write strobe
	input wire emb_pkg::emb_word_t wr_mask,     // don't-care bits
	input wire logic               rd_strobe,   // read strobe
	input wire emb_pkg::emb_word_t rd_data,     // answer data
	input wire logic               rd_valid,    // answer valid
	input wire logic               match_found, // hit flag
	input wire logic               unenc_half   // upper lines
);
	import emb_pkg::*;

	property p_unenc_pair;
		@(posedge rd_clk) disable iff (sys_rst || aclr)
		rd_valid && !unenc_half && cam_unenc && mode == EMB_CAM |=> rd_valid && unenc_half;
	endproperty
	a_unenc_pair: assert property (p_unenc_pair)
		else $error("upper match half missing");

	property p_enc_none;
		@(posedge rd_clk) disable iff (sys_rst || aclr)
		rd_valid && !cam_unenc && mode == EMB_CAM && !match_found |-> rd_data == 32'h0000_0000;
	endproperty
	a_enc_none: assert property (p_enc_none)
		else $error("address given without a hit");

	property p_rd_latency;
		@(posedge rd_clk) disable iff (sys_rst || aclr)
		path_reg == 6'h00 && rd_strobe && clk_en && mode == EMB_RAM |=> rd_valid;
	endproperty
	a_rd_latency: assert property (p_rd_latency)
		else $error("bypassed read late");

	property p_rd_stage;
		@(posedge rd_clk) disable iff (sys_rst || aclr)
		path_reg == 6'h02 && rd_strobe && clk_en && mode == EMB_RAM |-> ##2 rd_valid;
	endproperty
	a_rd_stage: assert property (p_rd_stage)
		else $error("output stage read not two cycles");

	property p_valid_cause;
		@(posedge rd_clk) disable iff (sys_rst || aclr)
		path_reg == 6'h00 && mode == EMB_RAM && rd_valid |-> $past(rd_strobe) && $past(clk_en);
	endproperty
	a_valid_cause: assert property (p_valid_cause)
		else $error("answer without enabled strobe");

	property p_aclr;
		@(posedge rd_clk) disable iff (sys_rst)
		aclr |-> !rd_valid && !match_found && !unenc_half && rd_data == 32'h0000_0000;
	endproperty
	a_aclr: assert property (p_aclr)
		else $error("outputs not cleared");

	property p_hold2;
		@(posedge core_clk) disable iff (sys_rst)
		$rose(wr_strobe) && mode == EMB_CAM && wr_mask == 32'h0000_0000 |-> wr_strobe [*2] ##1 !wr_strobe;
	endproperty
	a_hold2: assert property (p_hold2)
		else $error("plain word strobe not two cycles");

	property p_hold3;
		@(posedge core_clk) disable iff (sys_rst)
		$rose(wr_strobe) && mode == EMB_CAM && wr_mask != 32'h0000_0000 |-> wr_strobe [*3] ##1 !wr_strobe;
	endproperty
	a_hold3: assert property (p_hold3)
		else $error("masked word strobe not three cycles");
endmodule : emb_chk

// ==== test/tb_top.sv ====
// bench: user end and memory block joined, driven through user requests
`timescale 1ns/1ps
module tb_top;
	import emb_pkg::*;
	localparam emb_word_t nm = 32'h0000_0000;
	logic      core_clk;
	logic      sys_rst;
	wire       rd_clk = core_clk;
	emb_mode_t u_mode;
	emb_path_t u_path_reg;
	logic      u_unenc, u_clk_en, u_clear, u_cfg_go, u_wr_go, u_rd_go;
	emb_addr_t u_wr_addr, u_rd_addr;
	emb_word_t u_wr_data, u_wr_mask, u_key, u_rd_data, got_d, got_d2;
	logic      u_wr_busy, u_rd_valid, u_found, u_half, got_v, got_f, got_h, got_h2;
	int        miscompares = 0, n_checks = 0, cycles = 0, wr_n;
	emb_path_t paths [2] = '{6'h02, 6'h3f};
	emb_if     bus ();
	emb_block i_emb_block (.core_clk(core_clk), .rd_clk(rd_clk), .sys_rst(sys_rst), .bus(bus));
	emb_user i_emb_user (.core_clk(core_clk), .rd_clk(rd_clk), .sys_rst(sys_rst), .bus(bus), .u_mode(u_mode),
		.u_path_reg(u_path_reg), .u_unenc(u_unenc), .u_clk_en(u_clk_en), .u_clear(u_clear), .u_cfg_go(u_cfg_go),
		.u_wr_go(u_wr_go), .u_wr_addr(u_wr_addr), .u_wr_data(u_wr_data), .u_wr_mask(u_wr_mask),
		.u_wr_busy(u_wr_busy), .u_rd_go(u_rd_go), .u_rd_addr(u_rd_addr), .u_key(u_key), .u_rd_data(u_rd_data),
		.u_rd_valid(u_rd_valid), .u_found(u_found), .u_half(u_half));
	emb_chk i_emb_chk (.core_clk(core_clk), .rd_clk(rd_clk), .sys_rst(sys_rst), .mode(bus.mode),
		.path_reg(bus.path_reg), .cam_unenc(bus.cam_unenc), .clk_en(bus.clk_en), .aclr(bus.aclr),
		.wr_strobe(bus.wr_strobe), .wr_mask(bus.wr_mask), .rd_strobe(bus.rd_strobe), .rd_data(bus.rd_data),
		.rd_valid(bus.rd_valid), .match_found(bus.match_found), .unenc_half(bus.unenc_half));

	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic stop_test();
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	// whole run needs a few hundred cycles
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares = miscompares + 1;
			stop_test();
		end
	end

	task automatic chk(input emb_word_t got, input emb_word_t exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic do_reset();
		sys_rst = 1'b1;
		repeat (10) @(negedge core_clk);
		sys_rst = 1'b0;
	endtask : do_reset

	task automatic cfg(input emb_mode_t m, input emb_path_t p, input logic un);
		u_mode = m;
		u_path_reg = p;
		u_unenc = un;
		repeat (3) @(negedge core_clk);
	endtask : cfg

	// busy cycles counted so the cam hold length is visible
	task automatic wr(input emb_addr_t a, input emb_word_t d, input emb_word_t m);
		u_wr_addr = a;
		u_wr_data = d;
		u_wr_mask = m;
		u_wr_go = 1'b1;
		@(negedge core_clk);
		u_wr_go = 1'b0;
		wr_n = 0;
		while (u_wr_busy === 1'b1 && wr_n < 8)
		begin
			wr_n++;
			@(negedge core_clk);
		end
	endtask : wr

	task automatic preload(input emb_addr_t a, input emb_word_t d);
		u_wr_addr = a;
		u_wr_data = d;
		u_wr_mask = nm;
		u_cfg_go = 1'b1;
		@(negedge core_clk);
		u_cfg_go = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask : preload

	// second sample taken for the upper half of unencoded answers
	task automatic rd(input emb_addr_t a, input emb_word_t k);
		u_rd_addr = a;
		u_key = k;
		u_rd_go = 1'b1;
		@(negedge core_clk);
		u_rd_go = 1'b0;
		for (int i = 0; i < 8 && u_rd_valid !== 1'b1; i++)
			@(negedge core_clk);
		got_v = u_rd_valid;
		got_d = u_rd_data;
		got_f = u_found;
		got_h = u_half;
		@(negedge core_clk);
		got_d2 = u_rd_data;
		got_h2 = u_half;
		@(negedge core_clk);
	endtask : rd

	initial
	begin
		sys_rst = 1'b1;
		{u_mode, u_path_reg, u_unenc, u_clear, u_cfg_go, u_wr_go, u_rd_go} = '0;
		{u_wr_addr, u_rd_addr, u_wr_data, u_wr_mask, u_key} = '0;
		u_clk_en = 1'b1;
		do_reset();
		wr(5'h03, 32'ha5a5_0003, nm);
		wr(5'h1f, 32'h5a5a_001f, nm);
		fork
			wr(5'h04, 32'h0f0f_0004, nm);
			rd(5'h03, nm);
		join
		chk(got_d, 32'ha5a5_0003);
		rd(5'h1f, nm);
		chk(got_d, 32'h5a5a_001f);
		rd(5'h04, nm);
		chk(got_d, 32'h0f0f_0004);
		u_clk_en = 1'b0;
		rd(5'h04, nm);
		chk(emb_word_t'(got_v), 32'h0000_0000);
		u_clk_en = 1'b1;
		for (int j = 0; j < 2; j++)
		begin
			cfg(EMB_RAM, paths[j], 1'b0);
			wr(5'h09, 32'h3c3c_0000 | emb_word_t'(paths[j]), nm);
			rd(5'h09, nm);
			chk(got_d, 32'h3c3c_0000 | emb_word_t'(paths[j]));
		end
		cfg(EMB_ROM, 6'h00, 1'b0);
		preload(5'h07, 32'h1111_2222);
		wr(5'h07, 32'h3333_4444, nm);
		rd(5'h07, nm);
		chk(got_d, 32'h1111_2222);
		// reset empties the fifo pointers; the array survives it
		do_reset();
		cfg(EMB_FIFO, 6'h00, 1'b0);
		rd(5'h00, nm);
		chk(emb_word_t'(got_v), 32'h0000_0000);
		for (int j = 0; j < 3; j++)
			wr(5'h00, 32'hf1f0_0000 + j, nm);
		repeat (6) @(negedge core_clk);
		chk(emb_word_t'(bus.fifo_empty), 32'h0000_0000);
		for (int j = 0; j < 3; j++)
		begin
			rd(5'h00, nm);
			chk(got_d, 32'hf1f0_0000 + j);
		end
		chk(emb_word_t'(bus.fifo_empty), 32'h0000_0001);
		for (int j = 0; j < 32; j++)
			wr(5'h00, 32'h0000_0000, nm);
		chk(emb_word_t'(bus.fifo_full), 32'h0000_0001);
		do_reset();
		cfg(EMB_CAM, 6'h00, 1'b0);
		wr(5'h0c, 32'h1234_5678, nm);
		chk(emb_word_t'(wr_n), 32'h0000_0002);
		wr(5'h14, 32'h0bad_f00d, 32'h0000_00ff);
		chk(emb_word_t'(wr_n), 32'h0000_0003);
		wr(5'h00, 32'h5555_aaaa, nm);
		preload(5'h05, 32'h7777_0005);
		rd(5'h00, 32'h1234_5678);
		chk(got_d, 32'h0000_000c);
		chk(emb_word_t'(got_f), 32'h0000_0001);
		rd(5'h00, 32'h0bad_f0a5);
		chk(got_d, 32'h0000_0014);
		rd(5'h00, 32'h5555_aaaa);
		chk(got_d, 32'h0000_0000);
		rd(5'h00, 32'h7777_0005);
		chk(got_d, 32'h0000_0005);
		rd(5'h00, 32'h1bad_f00d);
		chk(emb_word_t'(got_f), 32'h0000_0000);
		cfg(EMB_CAM, 6'h00, 1'b1);
		wr(5'h1f, 32'h1234_5678, nm);
		rd(5'h00, 32'h1234_5678);
		chk({16'h0000, got_d[15:0]}, 32'h0000_1000);
		chk(emb_word_t'({got_h, got_h2}), 32'h0000_0001);
		chk({16'h0000, got_d2[15:0]}, 32'h0000_8000);
		rd(5'h00, 32'hffff_ffff);
		chk({got_d2[15:0], got_d[15:0]}, 32'h0000_0000);
		u_clear = 1'b1;
		repeat (3) @(negedge core_clk);
		u_clear = 1'b0;
		repeat (2) @(negedge core_clk);
		rd(5'h00, 32'h5555_aaaa);
		chk({16'h0000, got_d[15:0]}, 32'h0000_0001);
		stop_test();
	end
endmodule : tb_top
